/* File: hdl/rcg_top.sv */
// reference clock generator: apb control register, source select and 15-bit divider
// assumes source clocks sampled synchronously to clk, and idle/sleep levels from the power controller
//
// The implementer's own choices: register access over APB and the register addresses.
module rcg_top (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [15:0] src_clk,
    input wire logic idle_mode,
    input wire logic sleep_mode,
    output logic ref_clk,
    output logic reference_clock_out_pin,
    output logic reference_clock_out_pin_oe_n
);
    typedef struct packed {
        logic [14:0] divider_value;
        logic [14:0] div_live;
        logic enable;
        logic stop_in_idle;
        logic out_en;
        logic run_in_sleep;
        logic divider_switch_request;
        logic [3:0] source_select;
        logic src_prev;
        logic [15:0] cnt;
        logic clk_q;
        logic pin_q;
        logic [31:0] rdata;
    } rcg_state_s;

    rcg_state_s st;
    rcg_state_s next_st;
    logic src_now;
    logic src_edge;
    logic running;
    logic active;
    logic wr;
    logic rd;
    logic hit;
    logic [15:0] half;
    logic [31:0] ctrl_view;

    assign src_now = src_clk[st.source_select];
    assign src_edge = src_now & ~st.src_prev;
    // sleep gating applies only to sources where run-in-sleep is honoured
    assign running = st.enable
        & ~(idle_mode & st.stop_in_idle)
        & ~(sleep_mode & ~st.run_in_sleep & (st.source_select != rcg_pkg::SEL_NOSLEEP0)
            & (st.source_select != rcg_pkg::SEL_NOSLEEP1));
    assign active = running;
    assign wr = psel & penable & pwrite;
    assign rd = psel & ~penable & ~pwrite;
    assign hit = (paddr == rcg_pkg::CTRL_ADDR) || (paddr == rcg_pkg::DIVNOW_ADDR);
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~hit;
    assign half = {1'b0, st.div_live};
    assign prdata = st.rdata;
    assign ref_clk = st.clk_q;
    assign reference_clock_out_pin = st.pin_q;
    assign reference_clock_out_pin_oe_n = ~st.out_en;

    always_comb begin
        ctrl_view = rcg_pkg::CTRL_RESET;
        ctrl_view[rcg_pkg::DIV_MSB:rcg_pkg::DIV_LSB] = st.divider_value;
        ctrl_view[rcg_pkg::ON_BIT] = st.enable;
        ctrl_view[rcg_pkg::IDLE_STOP_BIT] = st.stop_in_idle;
        ctrl_view[rcg_pkg::OE_BIT] = st.out_en;
        ctrl_view[rcg_pkg::SLEEP_RUN_BIT] = st.run_in_sleep;
        ctrl_view[rcg_pkg::SWREQ_BIT] = st.divider_switch_request;
        ctrl_view[rcg_pkg::ACT_BIT] = active;
        ctrl_view[rcg_pkg::SEL_MSB:rcg_pkg::SEL_LSB] = st.source_select;
    end

    always_comb begin
        next_st = st;
        next_st.src_prev = src_now;
        if (rd) begin
            next_st.rdata = 32'h0000_0000;
            if (paddr == rcg_pkg::CTRL_ADDR) begin
                next_st.rdata = ctrl_view;
            end else if (paddr == rcg_pkg::DIVNOW_ADDR) begin
                next_st.rdata[rcg_pkg::DIV_MSB:rcg_pkg::DIV_LSB] = st.div_live;
            end
        end
        // a pending switch completes at the next source edge or at once while off, before any write of this cycle, which wins
        if (st.divider_switch_request && (src_edge || !st.enable)) begin
            next_st.div_live = st.divider_value;
            next_st.divider_switch_request = 1'b0;
        end
        if (wr && paddr == rcg_pkg::CTRL_ADDR) begin
            // software is expected to leave source and divider alone while active
            next_st.divider_value = pwdata[rcg_pkg::DIV_MSB:rcg_pkg::DIV_LSB];
            next_st.enable = pwdata[rcg_pkg::ON_BIT];
            next_st.stop_in_idle = pwdata[rcg_pkg::IDLE_STOP_BIT];
            next_st.out_en = pwdata[rcg_pkg::OE_BIT];
            next_st.run_in_sleep = pwdata[rcg_pkg::SLEEP_RUN_BIT];
            next_st.source_select = pwdata[rcg_pkg::SEL_MSB:rcg_pkg::SEL_LSB];
            if (pwdata[rcg_pkg::SWREQ_BIT]) begin
                next_st.divider_switch_request = 1'b1;
            end
            if (!st.enable) begin
                // while off a new divider takes effect directly
                next_st.div_live = pwdata[rcg_pkg::DIV_MSB:rcg_pkg::DIV_LSB];
            end
        end
        if (!running) begin
            next_st.clk_q = 1'b0;
            next_st.cnt = rcg_pkg::CNT_ZERO;
        end else if (st.div_live == rcg_pkg::DIV_ZERO) begin
            // divider zero passes the source straight through
            next_st.clk_q = src_now;
            next_st.cnt = rcg_pkg::CNT_ZERO;
        end else if (src_edge) begin
            // toggle every div_live source edges: output period is 2*div_live source periods
            if (st.cnt + rcg_pkg::CNT_ONE >= half) begin
                next_st.clk_q = ~st.clk_q;
                next_st.cnt = rcg_pkg::CNT_ZERO;
            end else begin
                next_st.cnt = st.cnt + rcg_pkg::CNT_ONE;
            end
        end
        // gate with the new enable so the pin never lags the bit by a cycle
        next_st.pin_q = next_st.out_en & next_st.clk_q;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // every check below samples on clk and is off while reset is low

    a_off_low: assert property (@(posedge clk) disable iff (!rst_n)
        !running |=> !st.clk_q) else $error("clock not low while stopped");
    a_sw_clear: assert property (@(posedge clk) disable iff (!rst_n)
        st.divider_switch_request && !st.enable && !wr |=> !st.divider_switch_request)
        else $error("switch not completed while off");
    a_pend_hold: assert property (@(posedge clk) disable iff (!rst_n)
        st.enable && !st.divider_switch_request && !wr |=> $stable(st.div_live))
        else $error("divider changed without switch");

    a_pin_gate: assert property (@(posedge clk) disable iff (!rst_n)
        !st.out_en |-> !reference_clock_out_pin) else $error("pin driven while disabled");
    a_pin_follow: assert property (@(posedge clk) disable iff (!rst_n)
        reference_clock_out_pin == (st.out_en & st.clk_q)) else $error("pin does not follow clock");

    a_idle_stop: assert property (@(posedge clk) disable iff (!rst_n)
        idle_mode && st.stop_in_idle |-> !active) else $error("active in idle with stop");
    a_sleep_gate: assert property (@(posedge clk) disable iff (!rst_n)
        sleep_mode && !st.run_in_sleep && st.source_select > rcg_pkg::SEL_NOSLEEP1 |-> !active)
        else $error("active in sleep");
    // the run-in-sleep bit must also keep the clock alive, not only stop it
    a_sleep_run: assert property (@(posedge clk) disable iff (!rst_n)
        st.enable && sleep_mode && st.run_in_sleep && !(idle_mode && st.stop_in_idle) |-> active)
        else $error("stopped in sleep with run bit");
    a_sleep_ign: assert property (@(posedge clk) disable iff (!rst_n)
        st.enable && !idle_mode && st.source_select <= rcg_pkg::SEL_NOSLEEP1 |-> active)
        else $error("sleep bit not ignored");

    a_on_active: assert property (@(posedge clk) disable iff (!rst_n)
        !st.enable |-> !active) else $error("active while off");
    a_off_clock: assert property (@(posedge clk) disable iff (!rst_n)
        !st.enable |=> !st.clk_q && !reference_clock_out_pin)
        else $error("clock running while off");

    a_div_read: assert property (@(posedge clk) disable iff (!rst_n)
        wr && paddr == rcg_pkg::CTRL_ADDR |=> st.divider_value == $past(pwdata[rcg_pkg::DIV_MSB:rcg_pkg::DIV_LSB]))
        else $error("divider field not stored");
    // between source edges the divided clock must hold still
    a_div_hold: assert property (@(posedge clk) disable iff (!rst_n)
        running && st.div_live != rcg_pkg::DIV_ZERO && !src_edge |=> $stable(st.clk_q))
        else $error("divided clock moved off a source edge");
    a_pass_thru: assert property (@(posedge clk) disable iff (!rst_n)
        running && st.div_live == rcg_pkg::DIV_ZERO |=> st.clk_q == $past(src_now))
        else $error("zero divider does not pass source");

    a_act_read: assert property (@(posedge clk) disable iff (!rst_n)
        rd && paddr == rcg_pkg::CTRL_ADDR |=> prdata[rcg_pkg::ACT_BIT] == $past(active))
        else $error("status bit wrong");
    a_rd_unmapped: assert property (@(posedge clk) disable iff (!rst_n)
        rd && !hit |=> prdata == 32'h0000_0000)
        else $error("unmapped read not zero");

    // a switch has two steps: request meets a source edge, then live value loads and the bit drops
    sequence s_switch_due;
        st.divider_switch_request && st.enable && src_edge && !wr;
    endsequence
    sequence s_switch_taken;
        !st.divider_switch_request && (st.div_live == $past(st.divider_value));
    endsequence
    a_sw_apply: assert property (@(posedge clk) disable iff (!rst_n)
        s_switch_due |=> s_switch_taken) else $error("switch not applied on source edge");
    // a software set wins over a hardware clear in the same cycle
    a_sw_set: assert property (@(posedge clk) disable iff (!rst_n)
        wr && paddr == rcg_pkg::CTRL_ADDR && pwdata[rcg_pkg::SWREQ_BIT] |=> st.divider_switch_request)
        else $error("switch request lost");
    // while off there is nothing to glitch, so the divider loads at once
    a_off_direct: assert property (@(posedge clk) disable iff (!rst_n)
        wr && paddr == rcg_pkg::CTRL_ADDR && !st.enable |=> st.div_live == $past(pwdata[rcg_pkg::DIV_MSB:rcg_pkg::DIV_LSB]))
        else $error("divider not loaded while off");
endmodule // rcg_top

/* File: shared/rcg_pkg.sv */
// package for the reference clock generator: register map, field layout, reset values
// assumes an apb slave at 32-bit data with one word per register
package rcg_pkg;
    localparam logic [11:0] CTRL_ADDR = 12'h000;
    localparam logic [11:0] DIVNOW_ADDR = 12'h004;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam int DIV_LSB = 16;
    localparam int DIV_MSB = 30;
    localparam int ON_BIT = 15;
    localparam int IDLE_STOP_BIT = 13;
    localparam int OE_BIT = 12;
    localparam int SLEEP_RUN_BIT = 11;
    localparam int SWREQ_BIT = 9;
    localparam int ACT_BIT = 8;
    localparam int SEL_LSB = 0;
    localparam int SEL_MSB = 3;
    localparam logic [14:0] DIV_ZERO = 15'h0000;
    localparam logic [14:0] DIV_ONE = 15'h0001;
    localparam logic [3:0] SEL_NOSLEEP0 = 4'h0;
    localparam logic [3:0] SEL_NOSLEEP1 = 4'h1;
    localparam logic [15:0] CNT_ONE = 16'h0001;
    localparam logic [15:0] CNT_ZERO = 16'h0000;
endpackage : rcg_pkg

/* File: sim/rcg_src_model.sv */
// source clock model: counter bits stand in for the selectable sources
// assumes clk is the system clock; bit i of src_clk has a period of 2^(i+1) clk cycles
module rcg_src_model (
    input wire logic clk,
    input wire logic rst_n,
    output logic [15:0] src_clk
);
    timeunit 1ns;
    timeprecision 1ns;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            src_clk <= 16'h0000;
        end else begin
            src_clk <= src_clk + 16'h0001;
        end
    end
endmodule // rcg_src_model

/* File: sim/test_reference_clock_generator.sv */
// testbench: apb master, source model, period and pin checks
// assumes source 0/1/2 periods of 2/4/8 clk from the model
module test_reference_clock_generator;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, rst_n, psel, penable, pwrite, idle_mode, sleep_mode, pready, pslverr, ref_clk, pin, pin_oe_n;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] src_clk;
    logic [31:0] cfg [3] = '{32'h0003_9200, 32'h0003_9201, 32'h0003_9A02};
    int fail_count, checked, cycles;
    rcg_src_model rcg_src_model_inst (.clk(clk), .rst_n(rst_n), .src_clk(src_clk));
    rcg_top rcg_top_inst (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .src_clk(src_clk), .idle_mode(idle_mode), .sleep_mode(sleep_mode), .ref_clk(ref_clk),
        .reference_clock_out_pin(pin), .reference_clock_out_pin_oe_n(pin_oe_n));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fail_count = fail_count + 1;
            conclude();
        end
    end
    task automatic conclude();
        if (fail_count == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // one transfer; holds the request until pready is seen high at an edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic err);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        chk({31'h0, pslverr}, {31'h0, err});
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic period(input logic [31:0] exp);
        time t0;
        @(posedge ref_clk);
        t0 = $time;
        @(posedge ref_clk);
        #1;
        chk(32'(($time - t0) / 20), exp);
        chk({31'h0, pin}, {31'h0, ref_clk});
    endtask
    task automatic quiet();
        repeat (60) begin
            @(posedge clk);
            chk({30'h0, ref_clk, pin}, 32'h0);
        end
    endtask
    initial begin
        {rst_n, psel, penable, pwrite, idle_mode, sleep_mode} = 6'h00;
        paddr = 12'h000;
        pwdata = 32'h0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        apb(1'b0, rcg_pkg::CTRL_ADDR, 32'h0, 1'b0);
        chk(rd, rcg_pkg::CTRL_RESET);
        chk({31'h0, pin_oe_n}, 32'h1);
        apb(1'b1, rcg_pkg::CTRL_ADDR, 32'hFFFF_7EF2, 1'b0);
        apb(1'b0, rcg_pkg::CTRL_ADDR, 32'h0, 1'b0);
        chk(rd, 32'h7FFF_3802);
        chk({31'h0, pin_oe_n}, 32'h0);
        quiet();
        apb(1'b1, 12'h008, 32'hFFFF_FFFF, 1'b1);
        apb(1'b0, 12'h008, 32'h0, 1'b1);
        chk(rd, 32'h0);
        apb(1'b1, rcg_pkg::DIVNOW_ADDR, 32'h0, 1'b0);
        apb(1'b0, rcg_pkg::DIVNOW_ADDR, 32'h0, 1'b0);
        chk(rd, 32'h7FFF_0000);
        apb(1'b1, rcg_pkg::CTRL_ADDR, 32'h0003_9202, 1'b0);
        period(48);
        apb(1'b0, rcg_pkg::CTRL_ADDR, 32'h0, 1'b0);
        chk(rd, 32'h0003_9102);
        // a divider written while on but stopped in idle is stored, yet the live divider keeps its value
        apb(1'b1, rcg_pkg::CTRL_ADDR, 32'h0003_B002, 1'b0);
        idle_mode <= 1'b1;
        repeat (4) @(posedge clk);
        quiet();
        apb(1'b1, rcg_pkg::CTRL_ADDR, 32'h0005_B002, 1'b0);
        apb(1'b0, rcg_pkg::DIVNOW_ADDR, 32'h0, 1'b0);
        chk(rd, 32'h0003_0000);
        apb(1'b0, rcg_pkg::CTRL_ADDR, 32'h0, 1'b0);
        chk(rd, 32'h0005_B002);
        idle_mode <= 1'b0;
        period(48);
        apb(1'b1, rcg_pkg::CTRL_ADDR, 32'h0005_9202, 1'b0);
        @(posedge ref_clk);
        period(80);
        @(posedge clk);
        sleep_mode <= 1'b1;
        repeat (4) @(posedge clk);
        quiet();
        for (int i = 0; i < 3; i++) begin
            apb(1'b1, rcg_pkg::CTRL_ADDR, 32'h0, 1'b0);
            apb(1'b1, rcg_pkg::CTRL_ADDR, cfg[i], 1'b0);
            period(12 << i);
            apb(1'b1, rcg_pkg::CTRL_ADDR, cfg[i] & 32'hFFFF_7FFF, 1'b0);
        end
        apb(1'b1, rcg_pkg::CTRL_ADDR, 32'h0000_9802, 1'b0);
        period(8);
        apb(1'b1, rcg_pkg::CTRL_ADDR, 32'h0000_1802, 1'b0);
        apb(1'b1, rcg_pkg::CTRL_ADDR, 32'h0, 1'b0);
        repeat (4) @(posedge clk);
        quiet();
        apb(1'b0, rcg_pkg::CTRL_ADDR, 32'h0, 1'b0);
        chk(rd, 32'h0);
        conclude();
    end
endmodule // test_reference_clock_generator
